// *** flf_pkg.sv ***
package flf_pkg;
    // Block layout, as byte indices within the returned block.
    localparam int BLOCK_LEN = 255;
    localparam logic [7:0] BYTE_COUNT = 8'hff;
    localparam logic [7:0] PTR_BYTE = 8'h00;
    localparam logic [7:0] CNT_BYTE = 8'h01;
    localparam logic [7:0] TS_LO = 8'h02;
    localparam logic [7:0] PKMN_LO = 8'h08;
    localparam logic [7:0] STAT_LO = 8'h30;
    localparam logic [7:0] CYC_LO = 8'h48;
    localparam logic [7:0] CYC_HI = 8'hed;
    localparam logic [7:0] RESERVED_VALUE = 8'h00;
    localparam logic [7:0] ALL_VALID = 8'hff;
    localparam logic [7:0] LAST_INDEX = 8'hff;

    // History record and ring geometry.
    localparam int REC_LEN = 46;
    localparam logic [7:0] POS_MAX = 8'h2d;
    localparam logic [7:0] CYC_LEN = 8'ha6;
    localparam int RING_LEN = 184;
    localparam logic [7:0] RING_MAX = 8'hb7;

    // Snapshot widths.
    localparam int TS_W = 41;
    localparam int PKMN_W = 320;
    localparam int STAT_W = 192;

    // Shared tick: one count per 200 us at a 25 MHz core clock.
    localparam int TICK_US = 200;
    localparam int CLK_MHZ = 25;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

    // Output buffer.
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } flf_state_t;
endpackage : flf_pkg

// *** flf_fifo.sv ***
`timescale 1ns/1ns
// Shift-register FIFO: the head entry is a flip-flop, so the drain side
// sees registered data and valid.
module flf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] data [DEPTH];
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = data[0];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            count <= next_count;
            out_valid <= (next_count != '0);
            in_ready <= (next_count < CW'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                data[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (pop) begin
                    if (push && CW'(i + 1) == count) begin
                        data[i] <= in_data;
                    end else if (i < DEPTH - 1) begin
                        data[i] <= data[i + 1];
                    end
                end else if (push && CW'(i) == count) begin
                    data[i] <= in_data;
                end
            end
        end
    end
endmodule : flf_fifo

// *** flf_formatter.sv ***
`timescale 1ns/1ns
// Behaviour
// RQ1: Byte 0 is captured history pointer.
// RQ2: Byte 1 is valid cyclic byte count.
// RQ3: Bytes 2-7: 41-bit tick timestamp, LSB first.
// RQ4: Bytes 8-47: peak/min pairs, fixed channel order.
// RQ5: Bytes 48-71: three status bytes per channel.
// RQ6: History records are 46 bytes, positions 0-45.
// RQ7: Fixed byte layout within each record.
// RQ8: Byte 72 at pointer, then descending.
// RQ9: Position wraps 0 to 45 of older record.
// RQ10: Cyclic to 237; 238-254 return zero.
// RQ11: Host reads all 255 bytes at once.
// RQ12: Count 0xFF precedes the pointer byte.
// RQ13: Writer stores byte, advances pointer, wraps 45.
module flf_formatter #(
    parameter int TICK_CYCLES = flf_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Telemetry history input, one byte per record position
    input wire logic HIST_VALID,
    input wire logic [7:0] HIST_DATA,
    // Fault capture
    input wire logic FAULT,
    input wire logic [flf_pkg::PKMN_W-1:0] PEAK_MIN,
    input wire logic [flf_pkg::STAT_W-1:0] CHAN_STATUS,
    // Block read request and byte stream to the bus engine
    input wire logic READ_START,
    output logic OUT_VALID,
    output logic [7:0] OUT_DATA,
    input wire logic OUT_READY,
    // Status
    output logic READ_BUSY,
    output logic LOG_LOCKED
);
    localparam int TW = $clog2(TICK_CYCLES);

    // History ring: four whole records, so a ring address modulo the
    // record length is always the record position.
    logic [7:0] ring [flf_pkg::RING_LEN];
    logic [7:0] wr_addr;
    logic [7:0] newest_now;
    logic [7:0] wr_pos;
    logic [7:0] wr_count;
    logic [TW-1:0] tick_div;
    logic [flf_pkg::TS_W-1:0] tick_count;

    // Snapshot taken at the fault.
    logic [7:0] snap_ptr;
    logic [7:0] snap_count;
    logic [7:0] snap_newest;
    logic [flf_pkg::TS_W-1:0] snap_ts;
    logic [flf_pkg::PKMN_W-1:0] snap_pkmn;
    logic [flf_pkg::STAT_W-1:0] snap_stat;

    // Readout pipeline.
    flf_pkg::flf_state_t state;
    logic [7:0] idx;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic s1_valid;
    logic s1_cyc;
    logic s1_ok;
    logic [7:0] s1_pre;
    logic fifo_ready;
    logic adv;
    logic issue;
    logic last;
    logic capture;
    logic [7:0] blk;
    logic [7:0] cyc_k;
    logic [47:0] ts_pad;
    logic next_cyc;
    logic [7:0] next_pre;
    logic [7:0] push_data;

    assign adv = !s1_valid || fifo_ready;
    assign issue = adv && (state == flf_pkg::ST_SEND);
    assign last = issue && (idx == flf_pkg::LAST_INDEX);
    assign capture = FAULT && !LOG_LOCKED && (state == flf_pkg::ST_IDLE);
    assign blk = idx - 8'h01;
    assign newest_now = (wr_addr == 8'h00) ? flf_pkg::RING_MAX :
        wr_addr - 8'h01;
    assign cyc_k = blk - flf_pkg::CYC_LO;
    assign ts_pad = {7'h00, snap_ts};

    // Shared tick counter, cleared only by reset.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            tick_div <= '0;
            tick_count <= '0;
        end else if (tick_div == TW'(TICK_CYCLES - 1)) begin
            tick_div <= '0;
            tick_count <= tick_count + 41'h1; // RQ3
        end else begin
            tick_div <= tick_div + TW'(1);
        end
    end

    // History writer. Writes stop while a snapshot is held so the ring
    // still matches the captured pointer when the host reads it.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            wr_addr <= 8'h00;
            wr_pos <= 8'h00;
            wr_count <= 8'h00;
        end else if (HIST_VALID && !LOG_LOCKED) begin
            wr_addr <= (wr_addr == flf_pkg::RING_MAX) ? 8'h00 :
                wr_addr + 8'h01;
            wr_pos <= (wr_pos == flf_pkg::POS_MAX) ? 8'h00 :
                wr_pos + 8'h01; // RQ13
            if (wr_count != flf_pkg::CYC_LEN) begin
                wr_count <= wr_count + 8'h01; // RQ2
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (HIST_VALID && !LOG_LOCKED) begin
            ring[wr_addr] <= HIST_DATA; // RQ6 RQ7 RQ13
        end
    end

    // Snapshot of pointer, count, time, extremes and status.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            snap_ptr <= 8'h00;
            snap_count <= 8'h00;
            snap_newest <= 8'h00;
            snap_ts <= '0;
            snap_pkmn <= '0;
            snap_stat <= '0;
        end else if (capture) begin
            snap_ptr <= (wr_pos == 8'h00) ? flf_pkg::POS_MAX :
                wr_pos - 8'h01; // RQ1
            snap_count <= wr_count; // RQ2
            snap_newest <= newest_now;
            snap_ts <= tick_count; // RQ3
            snap_pkmn <= PEAK_MIN; // RQ4
            snap_stat <= CHAN_STATUS; // RQ5
        end
    end

    // The lock is released only once the whole block has been issued.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            LOG_LOCKED <= 1'b0;
        end else if (capture) begin
            LOG_LOCKED <= 1'b1;
        end else if (last) begin
            LOG_LOCKED <= 1'b0;
        end
    end

    // Read sequencer: index 0 is the block byte count, index n is block
    // byte n-1.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state <= flf_pkg::ST_IDLE;
            idx <= 8'h00;
            READ_BUSY <= 1'b0;
        end else begin
            case (state)
                flf_pkg::ST_IDLE: begin
                    if (READ_START) begin
                        state <= flf_pkg::ST_SEND;
                        idx <= 8'h00;
                        READ_BUSY <= 1'b1;
                    end
                end
                flf_pkg::ST_SEND: begin
                    if (last) begin
                        state <= flf_pkg::ST_IDLE; // RQ11
                        READ_BUSY <= 1'b0;
                    end else if (issue) begin
                        idx <= idx + 8'h01;
                    end
                end
                default: begin
                    state <= flf_pkg::ST_IDLE;
                    READ_BUSY <= 1'b0;
                end
            endcase
        end
    end

    // Byte selection for the index being issued.
    always_comb begin
        next_pre = flf_pkg::RESERVED_VALUE;
        next_cyc = 1'b0;
        if (idx == 8'h00) begin
            next_pre = flf_pkg::BYTE_COUNT; // RQ12
        end else if (blk == flf_pkg::PTR_BYTE) begin
            next_pre = snap_ptr; // RQ1 RQ12
        end else if (blk == flf_pkg::CNT_BYTE) begin
            next_pre = (snap_count == flf_pkg::CYC_LEN) ?
                flf_pkg::ALL_VALID : snap_count; // RQ2
        end else if (blk < flf_pkg::PKMN_LO) begin
            next_pre = ts_pad[8 * (blk - flf_pkg::TS_LO) +: 8]; // RQ3
        end else if (blk < flf_pkg::STAT_LO) begin
            next_pre = snap_pkmn[8 * (blk - flf_pkg::PKMN_LO) +: 8]; // RQ4
        end else if (blk < flf_pkg::CYC_LO) begin
            next_pre = snap_stat[8 * (blk - flf_pkg::STAT_LO) +: 8]; // RQ5
        end else if (blk <= flf_pkg::CYC_HI) begin
            next_cyc = 1'b1; // RQ10
        end
    end

    // Ring walk: starts at the newest byte and steps down one address per
    // cyclic byte, so record positions fall and wrap from 0 to 45.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rd_addr <= 8'h00;
        end else if (state == flf_pkg::ST_IDLE && READ_START) begin
            // A fault taken on the same edge has not reached the snapshot
            // yet, so the walk must start from newest_now, one below the live write address.
            rd_addr <= capture ? newest_now : snap_newest; // RQ8
        end else if (issue && next_cyc) begin
            rd_addr <= (rd_addr == 8'h00) ? flf_pkg::RING_MAX :
                rd_addr - 8'h01; // RQ9
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (adv) begin
            rd_data <= ring[rd_addr];
        end
    end

    // Second stage holds its byte until the buffer takes it.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s1_valid <= 1'b0;
            s1_cyc <= 1'b0;
            s1_ok <= 1'b0;
            s1_pre <= 8'h00;
        end else if (adv) begin
            s1_valid <= issue;
            s1_cyc <= next_cyc;
            s1_ok <= (cyc_k < snap_count); // RQ2
            s1_pre <= next_pre;
        end
    end

    // History bytes past the valid count are sent as zero.
    assign push_data = (s1_cyc && !s1_ok) ? flf_pkg::RESERVED_VALUE :
        (s1_cyc ? rd_data : s1_pre);

    flf_fifo #(
        .WIDTH(flf_pkg::FIFO_W),
        .DEPTH(flf_pkg::FIFO_D)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .in_valid(s1_valid),
        .in_data(push_data),
        .in_ready(fifo_ready),
        .out_valid(OUT_VALID),
        .out_data(OUT_DATA),
        .out_ready(OUT_READY)
    );
endmodule : flf_formatter

// *** flf_host.sv ***
`timescale 1ns/1ns
// Bus host draining the block; it may stall, or take every second cycle.
module flf_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pacing from the bench
    input wire logic hold,
    input wire logic slow,
    // Byte stream
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready
);
    logic [7:0] rx [256];
    logic [7:0] idx;
    int got;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
            idx <= 8'h00;
            got <= 0;
        end else begin
            out_ready <= !hold && (!slow || !out_ready);
            if (out_valid && out_ready) begin
                rx[idx] <= out_data;
                idx <= idx + 8'h01;
                got <= got + 1;
            end
        end
    end
endmodule : flf_host

// *** flf_chk.sv ***
`timescale 1ns/1ns
module flf_chk (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Inputs
    input wire logic HIST_VALID,
    input wire logic FAULT,
    input wire logic [flf_pkg::PKMN_W-1:0] PEAK_MIN,
    input wire logic [flf_pkg::STAT_W-1:0] CHAN_STATUS,
    input wire logic READ_START,
    input wire logic OUT_READY,
    // Outputs
    input wire logic OUT_VALID,
    input wire logic [7:0] OUT_DATA,
    input wire logic READ_BUSY,
    input wire logic LOG_LOCKED
);
    logic [7:0] idx, ptr, cnt, n;
    logic [5:0] pos;
    logic [511:0] snap;
    logic cap, have;
    assign cap = FAULT && !LOG_LOCKED && !READ_BUSY;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Every read is 256 bytes long, so a wrapping count names the slot.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) idx <= 8'h00;
        else if (OUT_VALID && OUT_READY) idx <= idx + 8'h01;
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pos <= 6'h00;
            n <= 8'h00;
        end else if (HIST_VALID && !LOG_LOCKED) begin
            pos <= (pos == 6'h2d) ? 6'h00 : pos + 6'h01;
            n <= (n == 8'ha6) ? n : n + 8'h01;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) have <= 1'b0;
        else if (cap) have <= 1'b1;
    end
    always_ff @(posedge CORE_CLK) begin
        if (cap) begin
            ptr <= (pos == 6'h00) ? 8'h2d : 8'(pos - 6'h01);
            cnt <= (n == 8'ha6) ? 8'hff : n;
            snap <= {CHAN_STATUS, PEAK_MIN};
        end
    end
    property p_lock; cap |=> LOG_LOCKED; endproperty
    a_lock: assert property (p_lock) else $error("no lock");
    property p_go;
        READ_START && !READ_BUSY |=> READ_BUSY ##[0:7] OUT_VALID;
    endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_hold;
        OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
    endproperty
    a_hold: assert property (p_hold) else $error("drop");
    property p_cnt;
        OUT_VALID && idx == 8'h00 |-> OUT_DATA == 8'hff;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count");
    property p_ptr; have && OUT_VALID && idx == 8'h01 |-> OUT_DATA == ptr;
    endproperty
    a_ptr: assert property (p_ptr) else $error("ptr");
    property p_vc; have && OUT_VALID && idx == 8'h02 |-> OUT_DATA == cnt;
    endproperty
    a_vc: assert property (p_vc) else $error("valid");
    property p_ts; OUT_VALID && idx == 8'h08 |-> OUT_DATA[7:1] == 7'h00;
    endproperty
    a_ts: assert property (p_ts) else $error("stamp");
    property p_pre; have && OUT_VALID && idx inside {[9:72]}
        |-> OUT_DATA == snap[8*(int'(idx)-9) +: 8];
    endproperty
    a_pre: assert property (p_pre) else $error("preamble");
    property p_rsv; OUT_VALID && idx >= 8'hef |-> OUT_DATA == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    c_read: cover property (READ_START && !READ_BUSY);
    c_full: cover property ((OUT_VALID && !OUT_READY) [*8]);
    c_end: cover property (OUT_VALID && OUT_READY && idx == 8'hff);
endmodule : flf_chk
bind flf_formatter flf_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .HIST_VALID(HIST_VALID), .FAULT(FAULT), .PEAK_MIN(PEAK_MIN),
    .CHAN_STATUS(CHAN_STATUS), .READ_START(READ_START),
    .OUT_READY(OUT_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
    .READ_BUSY(READ_BUSY), .LOG_LOCKED(LOG_LOCKED));

// *** flf_formatter_tb_top.sv ***
`timescale 1ns/1ns
module flf_formatter_tb_top;
    logic clk, rst_n, hv, fault, start, ov, ordy, busy, locked, hold, slow;
    logic [7:0] hd, od;
    logic [flf_pkg::PKMN_W-1:0] pk;
    logic [flf_pkg::STAT_W-1:0] st;
    logic [7:0] hist [$];
    int fail_count = 0;
    int check_count = 0;
    int seq = 0;
    time t_rel, t_cap;
`define FLF_CHK(nm, exp, act) \
    begin check_count++; if ((act) !== (exp)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", nm, exp, act); end end
    flf_formatter #(.TICK_CYCLES(4)) DUT (.CORE_CLK(clk), .RST_N(rst_n),
        .HIST_VALID(hv), .HIST_DATA(hd), .FAULT(fault), .PEAK_MIN(pk),
        .CHAN_STATUS(st), .READ_START(start), .OUT_VALID(ov), .OUT_DATA(od),
        .OUT_READY(ordy), .READ_BUSY(busy), .LOG_LOCKED(locked));
    flf_host host (.clk(clk), .rst_n(rst_n), .hold(hold), .slow(slow),
        .out_valid(ov), .out_data(od), .out_ready(ordy));
    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic put_hist(input int n, input logic keep);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'(seq * 5 + 1);
            seq++;
            hv <= 1'b1;
            hd <= b;
            if (keep) hist.push_back(b);
            @(posedge clk);
        end
        hv <= 1'b0;
    endtask : put_hist
    task automatic capture();
        fault <= 1'b1;
        @(posedge clk);
        t_cap = $time;
        fault <= 1'b0;
        @(negedge clk);
        `FLF_CHK("lock", 1'b1, locked)
        @(posedge clk);
    endtask : capture
    task automatic do_read(input logic stall);
        int g0;
        int nv;
        logic [7:0] e;
        g0 = host.got;
        hold <= stall;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        // A stalled host lets the buffer fill until it refuses.
        if (stall) begin
            repeat (60) @(posedge clk);
            @(negedge clk);
            `FLF_CHK("stall busy", 1'b1, busy)
            `FLF_CHK("stall got", g0, host.got)
            @(posedge clk);
            hold <= 1'b0;
        end
        for (int i = 0; i < 4000 && host.got < g0 + 256; i++) @(posedge clk);
        if (host.got < g0 + 256) begin
            fail_count++;
            finish_test();
        end
        @(negedge clk);
        `FLF_CHK("unlock", 1'b0, locked)
        `FLF_CHK("busy end", 1'b0, busy)
        nv = (hist.size() >= 166) ? 166 : hist.size();
        `FLF_CHK("count", 8'hff, host.rx[0])
        `FLF_CHK("ptr", 8'((hist.size() - 1) % 46), host.rx[1])
        `FLF_CHK("valid", (nv == 166) ? 8'hff : 8'(nv), host.rx[2])
        for (int k = 8; k < 72; k++) begin
            e = (k < 48) ? pk[8*(k-8) +: 8] : st[8*(k-48) +: 8];
            `FLF_CHK("preamble", e, host.rx[k+1])
        end
        for (int k = 0; k < 183; k++) begin
            e = (k < nv) ? hist[hist.size() - 1 - k] : 8'h00;
            `FLF_CHK("cyclic", e, host.rx[k+73])
        end
        @(posedge clk);
    endtask : do_read
    task automatic sc_short();
        logic [15:0] ts;
        longint e_ts;
        slow <= 1'b1;
        put_hist(50, 1'b1);
        capture();
        // A fault while the log is held must not retake the snapshot.
        fault <= 1'b1;
        put_hist(5, 1'b0);
        fault <= 1'b0;
        do_read(1'b0);
        ts = {host.rx[4], host.rx[3]};
        e_ts = (t_cap - t_rel) / (40 * 4);
        `FLF_CHK("stamp", 1'b1, ts + 2 >= e_ts && ts <= e_ts + 1)
        `FLF_CHK("stamp top", 32'h0,
            {host.rx[8], host.rx[7], host.rx[6], host.rx[5]})
        slow <= 1'b0;
    endtask : sc_short
    task automatic sc_long();
        put_hist(200, 1'b1);
        capture();
        do_read(1'b1);
    endtask : sc_long
    task automatic sc_again();
        do_read(1'b0);
    endtask : sc_again
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst_n, hv, fault, start, hold, slow} <= 6'h00;
        hd <= 8'h00;
        for (int i = 0; i < 40; i++) pk[8*i +: 8] = 8'(3 * i + 1);
        for (int i = 0; i < 24; i++) st[8*i +: 8] = 8'(11 * i + 2);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_rel = $time;
        sc_short();
        sc_long();
        sc_again();
        finish_test();
    end
endmodule : flf_formatter_tb_top
